// ---- rtl/hardwired_option_registers.sv ----
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
// Function
// RULE1 - Option bits hardwired, not software alterable
// RULE2 - Stop-enable bit keeps detector alive in stop
// RULE3 - Rom protect blocks rom access
// RULE4 - Reset-disable bit gates detector reset
// RULE5 - Power-disable bit removes detector power
// RULE6 - Recovery delay 32 or 4096 cycles
// RULE7 - Use long recovery with external crystal
// RULE8 - Watchdog timeout long or short
// RULE9 - Stop illegal when stop disabled
// RULE10 - Watchdog-disable bit turns watchdog off
// RULE11 - Eeprom protect refuses writes to window
// RULE12 - Part values fixed as documented
// RULE13 - Reads return options, writes ignored
module hardwired_option_registers
  import option_pkg::*;
#(
  parameter int RECOVERY_LONG = RECOVERY_LONG_CYCLES,
  parameter int WATCHDOG_LONG = WATCHDOG_LONG_CYCLES,
  parameter int WATCHDOG_SHORT = WATCHDOG_SHORT_CYCLES
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic in_stop_mode,
  input wire logic lowvolt_reset_in,
  output logic lowvolt_detector_enable,
  output logic lowvolt_power_enable,
  output logic lowvolt_reset_out,
  input wire logic rom_access_req,
  output logic rom_access_grant,
  input wire logic stop_opcode,
  output logic stop_execute,
  output logic stop_illegal,
  input wire logic stop_wake,
  output logic cpu_resume,
  output logic recovering,
  output logic watchdog_enable,
  input wire logic watchdog_clear,
  output logic watchdog_reset,
  input wire logic ee_write_req,
  input wire logic [11:0] ee_addr,
  input wire logic ee_config_sel,
  output logic ee_write_grant,
  output logic ee_write_refused
);
  option_if opts ();
  option_source u_src (
    .opts(opts.src)
  );

  wire logic [7:0] oa = opts.opt_a;
  wire logic [7:0] ob = opts.opt_b;
  wire logic lv_stop = oa[BIT_LOWVOLT_STOP_ENABLE];
  wire logic rom_prot = oa[BIT_ROM_PROTECT];
  wire logic lv_rst_dis = oa[BIT_LOWVOLT_RESET_DISABLE];
  wire logic lv_pwr_dis = oa[BIT_LOWVOLT_POWER_DISABLE];
  wire logic short_rec = oa[BIT_SHORT_RECOVERY];
  wire logic wd_rate = oa[BIT_WATCHDOG_RATE_SELECT];
  wire logic stop_en = oa[BIT_STOP_ENABLE];
  wire logic wd_dis = oa[BIT_WATCHDOG_DISABLE];
  wire logic ee_prot = ob[BIT_EEPROM_PROTECT];

  // Register read; writes have no target at all
  // RULE13 - read hardwired values
  wire logic sel_a = (addr == ADDR_OPTION_A);
  wire logic sel_b = (addr == ADDR_OPTION_B);
  wire logic [7:0] rd_mux = sel_a ? oa : (sel_b ? ob : 8'h00);
  logic [7:0] rdata_r;
  always_ff @(posedge clk)
  begin
    if (reset)
      rdata_r <= 8'h00;
    else if (clk_en)
      rdata_r <= rd ? rd_mux : 8'h00;
  end
  assign rdata = rdata_r;

  // Pin inputs synchronised
  logic [1:0] s_stop, s_lvr, s_wake;
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      s_stop <= 2'b00;
      s_lvr <= 2'b00;
      s_wake <= 2'b00;
    end
    else if (clk_en)
    begin
      s_stop <= {s_stop[0], in_stop_mode};
      s_lvr <= {s_lvr[0], lowvolt_reset_in};
      s_wake <= {s_wake[0], stop_wake};
    end
  end
  wire logic stop_s = s_stop[1];
  wire logic lvr_s = s_lvr[1];
  wire logic wake_s = s_wake[1];

  // RULE5 - detector power
  assign lowvolt_power_enable = ~lv_pwr_dis;
  // RULE2 - detector in stop
  assign lowvolt_detector_enable = ~lv_pwr_dis & (~stop_s | lv_stop);
  // RULE4 - reset pass gate
  assign lowvolt_reset_out = lvr_s & ~lv_rst_dis & lowvolt_detector_enable;
  // RULE3 - rom block
  assign rom_access_grant = rom_access_req & ~rom_prot;
  // RULE9 - stop legality
  assign stop_execute = stop_opcode & stop_en;
  assign stop_illegal = stop_opcode & ~stop_en;

  // RULE11 - eeprom window check
  wire logic in_win = (ee_addr >= EEPROM_PROT_LO) &&
                      (ee_addr <= EEPROM_PROT_HI);
  wire logic ee_block = ee_prot & (in_win | ee_config_sel);
  assign ee_write_grant = ee_write_req & ~ee_block;
  assign ee_write_refused = ee_write_req & ee_block;

  // Stop recovery counter
  typedef enum {ST_RUN, ST_WAIT, ST_RECOVER} rec_e;
  rec_e st_r, st_nxt;
  logic [CNT_W-1:0] rcnt_r, rcnt_nxt;
  logic resume_r, resume_nxt;
  // RULE6 - recovery length select
  wire logic [CNT_W-1:0] rec_len = short_rec ?
    CNT_W'(RECOVERY_SHORT_CYCLES - 1) : CNT_W'(RECOVERY_LONG - 1);
  always_comb
  begin
    st_nxt = st_r;
    rcnt_nxt = rcnt_r;
    resume_nxt = 1'b0;
    unique case (st_r)
      ST_RUN:
        if (stop_s)
          st_nxt = ST_WAIT;
      ST_WAIT:
        if (wake_s)
        begin
          st_nxt = ST_RECOVER;
          rcnt_nxt = rec_len;
        end
      ST_RECOVER:
        if (rcnt_r == '0)
        begin
          st_nxt = ST_RUN;
          resume_nxt = 1'b1;
        end
        else
          rcnt_nxt = rcnt_r - 1'b1;
    endcase
  end
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st_r <= ST_RUN;
      rcnt_r <= '0;
      resume_r <= 1'b0;
    end
    else if (clk_en)
    begin
      st_r <= st_nxt;
      rcnt_r <= rcnt_nxt;
      resume_r <= resume_nxt;
    end
  end
  assign cpu_resume = resume_r;
  assign recovering = (st_r == ST_RECOVER);

  // Watchdog; frozen while stopped so stop cannot trip it
  // RULE10 - watchdog enable
  assign watchdog_enable = ~wd_dis;
  // RULE8 - timeout select
  wire logic [CNT_W-1:0] wd_len = wd_rate ?
    CNT_W'(WATCHDOG_LONG - 1) : CNT_W'(WATCHDOG_SHORT - 1);
  logic [CNT_W-1:0] wcnt_r;
  logic wrst_r;
  wire logic wd_run = watchdog_enable & (st_r == ST_RUN);
  wire logic wd_hit = wd_run & (wcnt_r >= wd_len);
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      wcnt_r <= '0;
      wrst_r <= 1'b0;
    end
    else if (clk_en)
    begin
      wrst_r <= wd_hit & ~watchdog_clear;
      if (watchdog_clear | wd_hit | ~watchdog_enable)
        wcnt_r <= '0;
      else if (wd_run)
        wcnt_r <= wcnt_r + 1'b1;
    end
  end
  assign watchdog_reset = wrst_r;

  wire logic unused_ok = &{1'b0, wdata, wr};
endmodule : hardwired_option_registers

// ---- rtl/option_if.sv ----
`timescale 1ns/100ps
interface option_if;
  logic [7:0] opt_a;
  logic [7:0] opt_b;
  modport src (output opt_a, output opt_b);
  modport dst (input opt_a, input opt_b);
endinterface : option_if

// ---- rtl/option_pkg.sv ----
package option_pkg;
  // Register indices; no offsets are printed, so these are chosen
  localparam logic [3:0] ADDR_OPTION_A = 4'h0;
  localparam logic [3:0] ADDR_OPTION_B = 4'h1;
  // Field positions, option register a
  localparam int BIT_LOWVOLT_STOP_ENABLE = 0;
  localparam int BIT_ROM_PROTECT = 1;
  localparam int BIT_LOWVOLT_RESET_DISABLE = 2;
  localparam int BIT_LOWVOLT_POWER_DISABLE = 3;
  localparam int BIT_SHORT_RECOVERY = 4;
  localparam int BIT_WATCHDOG_RATE_SELECT = 5;
  localparam int BIT_STOP_ENABLE = 6;
  localparam int BIT_WATCHDOG_DISABLE = 7;
  // Field positions, option register b
  localparam int BIT_EEPROM_PROTECT = 0;
  // RULE12 - hardwired part values
  localparam logic [7:0] OPTION_A_VALUE = 8'h61;
  localparam logic [7:0] OPTION_B_VALUE = 8'h01;
  // Timing counts in crystal clock cycles
  localparam int RECOVERY_SHORT_CYCLES = 32;
  localparam int RECOVERY_LONG_CYCLES = 4096;
  localparam int WATCHDOG_LONG_CYCLES = (1 << 18) - (1 << 4);
  localparam int WATCHDOG_SHORT_CYCLES = (1 << 13) - (1 << 4);
  // Protected eeprom window
  localparam logic [11:0] EEPROM_PROT_LO = 12'h8f0;
  localparam logic [11:0] EEPROM_PROT_HI = 12'h8ff;
  localparam int CNT_W = 18;
endpackage : option_pkg

// ---- rtl/option_source.sv ----
`timescale 1ns/100ps
module option_source
  import option_pkg::*;
#(
  parameter logic [7:0] A_VALUE = OPTION_A_VALUE,
  parameter logic [7:0] B_VALUE = OPTION_B_VALUE
)
(
  option_if.src opts
);
  // RULE1 - fixed wired constants
  assign opts.opt_a = A_VALUE;
  assign opts.opt_b = B_VALUE;
endmodule : option_source

// ---- test/hardwired_option_registers_props.sv ----
`timescale 1ns/100ps
module option_checker
  import option_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic clk_en,
  input wire logic [3:0] addr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic lowvolt_detector_enable,
  input wire logic lowvolt_power_enable,
  input wire logic rom_access_req,
  input wire logic rom_access_grant,
  input wire logic stop_opcode,
  input wire logic stop_execute,
  input wire logic stop_illegal,
  input wire logic cpu_resume,
  input wire logic recovering,
  input wire logic watchdog_enable,
  input wire logic ee_write_req,
  input wire logic [11:0] ee_addr,
  input wire logic ee_config_sel,
  input wire logic ee_write_refused
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  property p_read_a;
    rd && clk_en && addr == ADDR_OPTION_A |=> rdata == OPTION_A_VALUE;
  endproperty
  a_read_a: assert property (p_read_a) else $error("bad a read");
  property p_read_b;
    rd && clk_en && addr == ADDR_OPTION_B |=> rdata == OPTION_B_VALUE;
  endproperty
  a_read_b: assert property (p_read_b) else $error("bad b read");
  property p_det;
    lowvolt_detector_enable && lowvolt_power_enable;
  endproperty
  a_det: assert property (p_det) else $error("detector off");
  property p_rom;
    rom_access_grant == rom_access_req;
  endproperty
  a_rom: assert property (p_rom) else $error("rom gated");
  property p_stop;
    stop_execute == stop_opcode && !stop_illegal;
  endproperty
  a_stop: assert property (p_stop) else $error("stop wrong");
  property p_wd;
    watchdog_enable;
  endproperty
  a_wd: assert property (p_wd) else $error("watchdog off");
  property p_ee;
    ee_write_req && (ee_config_sel || ee_addr[11:4] == 8'h8f)
      |-> ee_write_refused;
  endproperty
  a_ee: assert property (p_ee) else $error("ee not refused");
  property p_resume;
    cpu_resume |-> $past(recovering) ##1 !cpu_resume;
  endproperty
  a_resume: assert property (p_resume) else $error("bad resume");
endmodule : option_checker
bind hardwired_option_registers option_checker chk_i (
  .clk(clk),
  .reset(reset),
  .clk_en(clk_en),
  .addr(addr),
  .rd(rd),
  .rdata(rdata),
  .lowvolt_detector_enable(lowvolt_detector_enable),
  .lowvolt_power_enable(lowvolt_power_enable),
  .rom_access_req(rom_access_req),
  .rom_access_grant(rom_access_grant),
  .stop_opcode(stop_opcode),
  .stop_execute(stop_execute),
  .stop_illegal(stop_illegal),
  .cpu_resume(cpu_resume),
  .recovering(recovering),
  .watchdog_enable(watchdog_enable),
  .ee_write_req(ee_write_req),
  .ee_addr(ee_addr),
  .ee_config_sel(ee_config_sel),
  .ee_write_refused(ee_write_refused)
);

// ---- test/hardwired_option_registers_tb.sv ----
`timescale 1ns/100ps
module hardwired_option_registers_tb
  import option_pkg::*;
;
  logic clk, reset, clk_en, wr, rd, in_stop_mode, lowvolt_reset_in;
  logic rom_access_req, stop_opcode, stop_wake, watchdog_clear;
  logic ee_write_req, ee_config_sel, lowvolt_detector_enable;
  logic [3:0] addr;
  logic [7:0] wdata, rdata;
  logic [11:0] ee_addr;
  logic lowvolt_power_enable, lowvolt_reset_out, rom_access_grant;
  logic stop_execute, stop_illegal, cpu_resume, recovering;
  logic watchdog_enable, watchdog_reset, ee_write_grant, ee_write_refused;
  int bad_count, check_count, n;
  logic [3:0] a;
  logic [11:0] ee_corner [4] = '{12'h8ef, 12'h8f0, 12'h8ff, 12'h900};
  hardwired_option_registers #(.RECOVERY_LONG(64), .WATCHDOG_LONG(300))
    dut (.*);
  initial
  begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  task chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task print_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : print_verdict
  function logic [7:0] exp_reg(input logic [3:0] x);
    return x == 0 ? 8'h61 : x == 1 ? 8'h01 : 8'h00;
  endfunction : exp_reg
  function logic exp_ref;
    return ee_write_req && (ee_config_sel || ee_addr[11:4] == 8'h8f);
  endfunction : exp_ref
  function logic watched(input int w);
    return w == 0 ? recovering : watchdog_reset;
  endfunction : watched
  // Wait on a level, bounded so a stuck output cannot hang the run
  task automatic wait_lvl(input int w, input logic v, input int lim);
    n = 0;
    while (watched(w) !== v && n < lim)
    begin
      @(posedge clk);
      #1 n++;
    end
  endtask : wait_lvl
  initial
  begin
    {wr, rd, in_stop_mode, lowvolt_reset_in, rom_access_req} = 0;
    {stop_opcode, stop_wake, watchdog_clear, ee_write_req} = 0;
    {ee_config_sel, addr, wdata, ee_addr} = 0;
    reset = 1;
    clk_en = 1;
    n = $urandom(92);
    repeat (2) @(posedge clk);
    reset <= 0;
    repeat (40)
    begin
      a = $urandom % 16;
      wr <= 1;
      addr <= a;
      wdata <= $urandom;
      @(posedge clk);
      wr <= 0;
      rd <= 1;
      @(posedge clk);
      rd <= 0;
      #1 chk(rdata, exp_reg(a));
    end
    // Frozen cycle: the second read must not be taken
    rd <= 1;
    addr <= ADDR_OPTION_A;
    @(posedge clk);
    addr <= ADDR_OPTION_B;
    clk_en <= 0;
    @(posedge clk);
    rd <= 0;
    clk_en <= 1;
    #1 chk(rdata, OPTION_A_VALUE);
    chk(rdata[BIT_SHORT_RECOVERY], 1'b0);
    $display("test registers done");
    repeat (40)
    begin
      rom_access_req <= $urandom;
      stop_opcode <= $urandom;
      ee_write_req <= $urandom;
      ee_config_sel <= $urandom % 4 == 0;
      ee_addr <= 12'h8e8 + $urandom % 32;
      @(posedge clk);
      #1 chk(rom_access_grant, rom_access_req);
      chk(stop_execute, stop_opcode);
      chk(ee_write_refused, exp_ref());
      chk(ee_write_grant, ee_write_req & !exp_ref());
    end
    // Window edges, just outside and just inside
    for (int i = 0; i < 4; i++)
    begin
      ee_write_req <= 1;
      ee_config_sel <= 0;
      ee_addr <= ee_corner[i];
      @(posedge clk);
      #1 chk(ee_write_refused, exp_ref());
    end
    $display("test gating done");
    lowvolt_reset_in <= 1;
    repeat (4) @(posedge clk);
    #1 chk(lowvolt_reset_out, 1);
    chk(lowvolt_power_enable, 1);
    chk(watchdog_enable, 1);
    chk(stop_illegal, 0);
    lowvolt_reset_in <= 0;
    in_stop_mode <= 1;
    repeat (4) @(posedge clk);
    #1 chk(lowvolt_detector_enable, 1);
    chk(lowvolt_reset_out, 0);
    // Leave stop as wake arrives so the block cannot stop again
    stop_wake <= 1;
    in_stop_mode <= 0;
    wait_lvl(0, 1, 20);
    stop_wake <= 0;
    wait_lvl(0, 0, 5000);
    chk(n, 64);
    chk(cpu_resume, 1);
    $display("test stop done");
    wait_lvl(1, 1, 700);
    @(posedge clk);
    #1 chk(watchdog_reset, 0);
    wait_lvl(1, 1, 400);
    chk(n + 1, 300);
    // A clear halfway restarts the full timeout
    repeat (150) @(posedge clk);
    watchdog_clear <= 1;
    @(posedge clk);
    watchdog_clear <= 0;
    #1 wait_lvl(1, 1, 400);
    chk(n, 300);
    $display("test watchdog done");
    print_verdict();
  end
  initial
  begin
    repeat (8000) @(posedge clk);
    bad_count++;
    print_verdict();
  end
endmodule : hardwired_option_registers_tb
